// ---- opaddr_pkg.sv ----
// Constants, modes and states of the operand address generator.
// Assumes a byte-wide program/data memory answering reads in one cycle.
//
// Notes on behaviour
// RULE_01: Inherent instructions are one byte; nothing is fetched after the opcode.
// RULE_02: Immediate mode fetches one byte and uses it as the operand value.
// RULE_03: Short direct fetches one address byte, zero-extended, reaching 00 to FF.
// RULE_04: Long direct fetches two bytes forming a full 16-bit address.
// RULE_05: Indexed address is the unsigned sum of X or Y and the offset.
// RULE_06: No-offset indexed fetches nothing; the index alone is the address.
// RULE_07: Short indexed adds a one-byte offset to the index, reaching 1FE.
// RULE_08: Long indexed adds a two-byte offset to the index, full space.
// RULE_09: Short indirect reads a byte pointer in page zero as address.
// RULE_10: Long indirect reads a 16-bit pointer word from page zero.
// RULE_11: Indirect indexed adds the index to the pointer read from page zero.
// RULE_12: Short indirect indexed: byte pointer plus index, up to 1FE, one byte.
// RULE_13: Long indirect indexed: word pointer plus index, whole space.
// RULE_14: Read-modify-write operations accept only short page-zero forms.
// RULE_15: Mask set gives level 3; mask clear gives level 0.
// RULE_16: Halt stops the oscillator; wait-for-irq sleeps until an interrupt.
// RULE_17: Words are high byte first; address sums are 16 bits.
package opaddr_pkg;

  // ==========================================================================
  // Addressing modes
  typedef enum logic [3:0] {
    MODE_INHERENT   = 4'h0,
    MODE_IMMEDIATE  = 4'h1,
    MODE_DIR_SHORT  = 4'h2,
    MODE_DIR_LONG   = 4'h3,
    MODE_IDX_NONE   = 4'h4,
    MODE_IDX_SHORT  = 4'h5,
    MODE_IDX_LONG   = 4'h6,
    MODE_IND_SHORT  = 4'h7,
    MODE_IND_LONG   = 4'h8,
    MODE_INDX_SHORT = 4'h9,
    MODE_INDX_LONG  = 4'hA
  } mode_type;

  // ==========================================================================
  // Inherent operation codes presented with an inherent request
  typedef enum logic [1:0] {
    OP_NONE            = 2'h0,
    OP_IRQ_MASK_SET    = 2'h1,
    OP_IRQ_MASK_CLEAR  = 2'h2,
    OP_SLEEP           = 2'h3
  } inh_op_type;

  // ==========================================================================
  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_B1    = 7'h02,
    ST_B2    = 7'h04,
    ST_PTRHI = 7'h08,
    ST_PTRLO = 7'h10,
    ST_DONE  = 7'h20,
    ST_LOWP  = 7'h40
  } state_type;

  // ==========================================================================
  // Field values and reset values
  localparam logic [1:0]  IRQ_LEVEL_MASKED   = 2'h3;
  localparam logic [1:0]  IRQ_LEVEL_OPEN     = 2'h0;
  localparam logic [1:0]  IRQ_LEVEL_RESET    = 2'h3;
  localparam logic [7:0]  PAGE_ZERO_HIGH     = 8'h00;
  localparam logic [15:0] ADDR_RESET         = 16'h0000;
  localparam logic [7:0]  BYTE_RESET         = 8'h00;

endpackage

// ---- opaddr_sum.sv ----
// Unsigned 16-bit adder of a base and an index register.
// Assumes both operands are stable for the cycle they are added in.
`timescale 1ns/1ns

module opaddr_sum (
  // Operands
  input  wire logic [15:0] base_in,
  input  wire logic [7:0]  index_in,
  // Result
  output logic      [15:0] sum_out
);

  // Carry out of bit 15 is dropped; the core wraps in a 64 Kbyte space.
  assign sum_out = base_in + {8'h00, index_in}; // RULE_17

endmodule // opaddr_sum

// ---- opaddr_gen.sv ----
// Operand fetch and effective-address generator of the CPU core.
// Assumes memory settles rd_data_in while rd_req_out is high, before the next edge.
`timescale 1ns/1ns

module opaddr_gen (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Decode request
  input  wire logic        start_in,
  input  wire logic [3:0]  mode_in,
  input  wire logic        use_y_in,
  input  wire logic        rmw_in,
  input  wire logic [1:0]  inh_op_in,
  input  wire logic [15:0] pc_in,
  // Index registers
  input  wire logic [7:0]  x_in,
  input  wire logic [7:0]  y_in,
  // Wake-up
  input  wire logic        irq_in,
  // Memory read port
  output logic             rd_req_out,
  output logic      [15:0] rd_addr_out,
  input  wire logic [7:0]  rd_data_in,
  // Results
  output logic             done_out,
  output logic             illegal_out,
  output logic             imm_valid_out,
  output logic      [7:0]  imm_out,
  output logic             addr_valid_out,
  output logic      [15:0] addr_out,
  output logic      [1:0]  len_out,
  output logic      [1:0]  irq_level_out,
  output logic             osc_stop_out,
  output logic             sleep_out,
  output logic             busy_out
);

  // ==========================================================================
  // Mode decoding
  function automatic logic [1:0] ext_bytes(input logic [3:0] m);
    case (m)
      opaddr_pkg::MODE_INHERENT,
      opaddr_pkg::MODE_IDX_NONE:  ext_bytes = 2'd0; // RULE_01 RULE_06
      opaddr_pkg::MODE_DIR_LONG,
      opaddr_pkg::MODE_IDX_LONG:  ext_bytes = 2'd2; // RULE_04 RULE_08
      default:                    ext_bytes = 2'd1; // RULE_02 RULE_03 RULE_07 RULE_09
    endcase
  endfunction

  function automatic logic is_short(input logic [3:0] m);
    is_short = (m == opaddr_pkg::MODE_DIR_SHORT) || (m == opaddr_pkg::MODE_IDX_NONE) ||
               (m == opaddr_pkg::MODE_IDX_SHORT) || (m == opaddr_pkg::MODE_IND_SHORT) ||
               (m == opaddr_pkg::MODE_INDX_SHORT);
  endfunction

  function automatic logic is_indexed(input logic [3:0] m);
    is_indexed = (m == opaddr_pkg::MODE_IDX_NONE) || (m == opaddr_pkg::MODE_IDX_SHORT) ||
                 (m == opaddr_pkg::MODE_IDX_LONG) || (m == opaddr_pkg::MODE_INDX_SHORT) ||
                 (m == opaddr_pkg::MODE_INDX_LONG);
  endfunction

  function automatic logic is_word_ptr(input logic [3:0] m);
    is_word_ptr = (m == opaddr_pkg::MODE_IND_LONG) || (m == opaddr_pkg::MODE_INDX_LONG);
  endfunction

  function automatic logic is_ptr(input logic [3:0] m);
    is_ptr = is_word_ptr(m) || (m == opaddr_pkg::MODE_IND_SHORT) ||
             (m == opaddr_pkg::MODE_INDX_SHORT);
  endfunction

  // ==========================================================================
  // Request capture
  opaddr_pkg::state_type state_reg;
  logic [3:0]  mode_reg;
  logic [7:0]  index_reg;
  logic [15:0] fetch_pc_reg;
  logic [15:0] base_reg;
  logic [1:0]  left_reg;
  logic [15:0] sum;
  logic        bad_rmw;

  // Long forms would reach outside page zero, which the RMW datapath cannot do.
  assign bad_rmw = rmw_in && !is_short(mode_in) &&
                   (mode_in != opaddr_pkg::MODE_INHERENT); // RULE_14

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_reg  <= 4'h0;
      index_reg <= 8'h00;
    end else if (state_reg == opaddr_pkg::ST_IDLE && start_in) begin
      mode_reg  <= mode_in;
      index_reg <= use_y_in ? y_in : x_in; // RULE_05
    end
  end

  opaddr_sum u_sum (
    .base_in  (base_reg),
    .index_in (index_reg),
    .sum_out  (sum)
  );

  // ==========================================================================
  // Sequencer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= opaddr_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        opaddr_pkg::ST_IDLE: begin
          if (start_in && !bad_rmw) begin
            if (ext_bytes(mode_in) != 2'd0) begin
              state_reg <= opaddr_pkg::ST_B1;
            end else if (mode_in == opaddr_pkg::MODE_INHERENT &&
                         inh_op_in == opaddr_pkg::OP_SLEEP) begin
              state_reg <= opaddr_pkg::ST_LOWP; // RULE_16
            end else begin
              state_reg <= opaddr_pkg::ST_DONE;
            end
          end
        end
        opaddr_pkg::ST_B1: begin
          if (left_reg == 2'd2) begin
            state_reg <= opaddr_pkg::ST_B2;
          end else if (is_ptr(mode_reg)) begin
            state_reg <= is_word_ptr(mode_reg) ? opaddr_pkg::ST_PTRHI
                                               : opaddr_pkg::ST_PTRLO;
          end else begin
            state_reg <= opaddr_pkg::ST_DONE;
          end
        end
        opaddr_pkg::ST_B2:    state_reg <= opaddr_pkg::ST_DONE;
        opaddr_pkg::ST_PTRHI: state_reg <= opaddr_pkg::ST_PTRLO;
        opaddr_pkg::ST_PTRLO: state_reg <= opaddr_pkg::ST_DONE;
        opaddr_pkg::ST_DONE:  state_reg <= opaddr_pkg::ST_IDLE;
        opaddr_pkg::ST_LOWP: begin
          if (irq_in) begin
            state_reg <= opaddr_pkg::ST_DONE; // RULE_16
          end
        end
        default: state_reg <= opaddr_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Memory reads: one byte per cycle, data back in the next state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_req_out   <= 1'b0;
      rd_addr_out  <= opaddr_pkg::ADDR_RESET;
      fetch_pc_reg <= opaddr_pkg::ADDR_RESET;
      left_reg     <= 2'd0;
    end else begin
      rd_req_out <= 1'b0;
      case (state_reg)
        opaddr_pkg::ST_IDLE: begin
          if (start_in && !bad_rmw && ext_bytes(mode_in) != 2'd0) begin
            rd_req_out   <= 1'b1;
            rd_addr_out  <= pc_in + 16'h0001;
            fetch_pc_reg <= pc_in + 16'h0002;
            left_reg     <= ext_bytes(mode_in);
          end
        end
        opaddr_pkg::ST_B1: begin
          if (left_reg == 2'd2) begin
            rd_req_out  <= 1'b1;
            rd_addr_out <= fetch_pc_reg; // RULE_04 RULE_08
          end else if (is_ptr(mode_reg)) begin
            rd_req_out  <= 1'b1;
            rd_addr_out <= {opaddr_pkg::PAGE_ZERO_HIGH, rd_data_in}; // RULE_09 RULE_10 RULE_11
          end
        end
        opaddr_pkg::ST_PTRHI: begin
          rd_req_out  <= 1'b1;
          rd_addr_out <= {opaddr_pkg::PAGE_ZERO_HIGH, rd_addr_out[7:0] + 8'h01}; // RULE_17
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Base assembly, high byte from the lower address
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      base_reg <= opaddr_pkg::ADDR_RESET;
    end else begin
      case (state_reg)
        opaddr_pkg::ST_IDLE:  base_reg <= opaddr_pkg::ADDR_RESET; // RULE_06
        opaddr_pkg::ST_B1:    base_reg <= (left_reg == 2'd2) ? {rd_data_in, 8'h00}
                                                             : {8'h00, rd_data_in}; // RULE_03
        opaddr_pkg::ST_B2:    base_reg <= {base_reg[15:8], rd_data_in}; // RULE_17
        opaddr_pkg::ST_PTRHI: base_reg <= {rd_data_in, 8'h00}; // RULE_10 RULE_13
        opaddr_pkg::ST_PTRLO: base_reg <= {base_reg[15:8], rd_data_in}; // RULE_09 RULE_12
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Results
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_out       <= 1'b0;
      illegal_out    <= 1'b0;
      imm_valid_out  <= 1'b0;
      imm_out        <= opaddr_pkg::BYTE_RESET;
      addr_valid_out <= 1'b0;
      addr_out       <= opaddr_pkg::ADDR_RESET;
      len_out        <= 2'd0;
    end else begin
      done_out       <= 1'b0;
      illegal_out    <= 1'b0;
      imm_valid_out  <= 1'b0;
      addr_valid_out <= 1'b0;
      if (state_reg == opaddr_pkg::ST_IDLE && start_in && bad_rmw) begin
        illegal_out <= 1'b1; // RULE_14
        done_out    <= 1'b1;
      end else if (state_reg == opaddr_pkg::ST_DONE) begin
        done_out <= 1'b1;
        len_out  <= ext_bytes(mode_reg); // RULE_01
        if (mode_reg == opaddr_pkg::MODE_IMMEDIATE) begin
          imm_valid_out <= 1'b1;
          imm_out       <= base_reg[7:0]; // RULE_02
        end else if (mode_reg != opaddr_pkg::MODE_INHERENT) begin
          addr_valid_out <= 1'b1;
          addr_out       <= is_indexed(mode_reg) ? sum : base_reg; // RULE_05 RULE_07 RULE_13
        end
      end
    end
  end

  // ==========================================================================
  // Interrupt level and power control
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_level_out <= opaddr_pkg::IRQ_LEVEL_RESET;
      osc_stop_out  <= 1'b0;
      sleep_out     <= 1'b0;
    end else begin
      if (state_reg == opaddr_pkg::ST_IDLE && start_in &&
          mode_in == opaddr_pkg::MODE_INHERENT) begin
        if (inh_op_in == opaddr_pkg::OP_IRQ_MASK_SET) begin
          irq_level_out <= opaddr_pkg::IRQ_LEVEL_MASKED; // RULE_15
        end else if (inh_op_in == opaddr_pkg::OP_IRQ_MASK_CLEAR) begin
          irq_level_out <= opaddr_pkg::IRQ_LEVEL_OPEN; // RULE_15
        end else if (inh_op_in == opaddr_pkg::OP_SLEEP) begin
          sleep_out    <= 1'b1; // RULE_16
          osc_stop_out <= !rmw_in; // RULE_16
        end
      end else if (state_reg == opaddr_pkg::ST_LOWP && irq_in) begin
        sleep_out    <= 1'b0;
        osc_stop_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state_reg == opaddr_pkg::ST_IDLE) ? (start_in && !bad_rmw)
                                                     : (state_reg != opaddr_pkg::ST_DONE);
    end
  end

endmodule // opaddr_gen

// ---- opaddr_gen_properties.sv ----
// Concurrent checks on the ports of the operand address generator.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns

module opaddr_gen_properties (
  // Clock, reset and request
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        start_in,
  input wire logic [3:0]  mode_in,
  input wire logic        rmw_in,
  input wire logic [1:0]  inh_op_in,
  input wire logic [15:0] pc_in,
  // Results
  input wire logic        rd_req_out,
  input wire logic [15:0] rd_addr_out,
  input wire logic        done_out,
  input wire logic        illegal_out,
  input wire logic        imm_valid_out,
  input wire logic        addr_valid_out,
  input wire logic [15:0] addr_out,
  input wire logic [1:0]  len_out,
  input wire logic [1:0]  irq_level_out,
  input wire logic        busy_out
);
  // ==========================================================================
  // Request capture
  logic [3:0] mode_reg;
  logic       rmw_reg;
  wire        take = start_in && !busy_out && !done_out;
  wire        fin  = done_out && addr_valid_out;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_reg <= 4'h0;
      rmw_reg  <= 1'b0;
    end else if (take) begin
      mode_reg <= mode_in;
      rmw_reg  <= rmw_in;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ==========================================================================
  // Checks
  chk_inh_no_fetch: assert property (take && mode_in == opaddr_pkg::MODE_INHERENT
    |=> !rd_req_out [*2]) else $error("inherent request fetched a byte");
  chk_imm_result: assert property (done_out && mode_reg == opaddr_pkg::MODE_IMMEDIATE
    && !rmw_reg |-> imm_valid_out && len_out == 2'h1) else $error("immediate result wrong");
  chk_page_zero: assert property (fin && (mode_reg == opaddr_pkg::MODE_DIR_SHORT
    || mode_reg == opaddr_pkg::MODE_IND_SHORT || mode_reg == opaddr_pkg::MODE_IDX_NONE)
    |-> addr_out[15:8] == 8'h00) else $error("short address left page zero");
  chk_long_len: assert property (fin && (mode_reg == opaddr_pkg::MODE_DIR_LONG
    || mode_reg == opaddr_pkg::MODE_IDX_LONG) |-> len_out == 2'h2) else $error("long length");
  chk_short_idx_range: assert property (fin && (mode_reg == opaddr_pkg::MODE_IDX_SHORT
    || mode_reg == opaddr_pkg::MODE_INDX_SHORT) |-> addr_out <= 16'h01FE)
    else $error("short indexed address beyond limit");
  chk_first_fetch: assert property (take && !rmw_in && mode_in != opaddr_pkg::MODE_INHERENT
    && mode_in != opaddr_pkg::MODE_IDX_NONE
    |=> rd_req_out && rd_addr_out == $past(pc_in) + 16'h0001) else $error("first fetch address");
  chk_mask_set: assert property (take && mode_in == opaddr_pkg::MODE_INHERENT
    && inh_op_in == opaddr_pkg::OP_IRQ_MASK_SET |-> ##[1:4] irq_level_out == 2'h3)
    else $error("mask set level");
  chk_mask_clear: assert property (take && mode_in == opaddr_pkg::MODE_INHERENT
    && inh_op_in == opaddr_pkg::OP_IRQ_MASK_CLEAR |-> ##[1:4] irq_level_out == 2'h0)
    else $error("mask clear level");
  chk_illegal_cause: assert property (done_out && illegal_out |-> rmw_reg)
    else $error("illegal flagged without rmw");
  chk_rmw_short_ok: assert property (done_out && rmw_reg
    && mode_reg == opaddr_pkg::MODE_DIR_SHORT |-> !illegal_out) else $error("short rmw refused");

endmodule // opaddr_gen_properties

bind opaddr_gen opaddr_gen_properties i_opaddr_gen_properties (.clk_in, .rst_in, .start_in,
  .mode_in, .rmw_in, .inh_op_in, .pc_in, .rd_req_out, .rd_addr_out, .done_out, .illegal_out,
  .imm_valid_out, .addr_valid_out, .addr_out, .len_out, .irq_level_out, .busy_out);

// ---- tb_top.sv ----
// Self-checking bench of the operand address generator.
// Assumes the bench plays the one-cycle byte memory behind the read port.
`timescale 1ns/1ns

module tb_top;
  logic clk_in = 1'b0, rst_in = 1'b1, start_in = 1'b0, use_y_in = 1'b0, rmw_in = 1'b0;
  logic irq_in = 1'b0, rd_req_out, done_out, illegal_out, imm_valid_out, addr_valid_out;
  logic osc_stop_out, sleep_out, busy_out;
  logic [3:0] mode_in = 4'h0;
  logic [1:0] inh_op_in = 2'h0, len_out, irq_level_out;
  logic [7:0] x_in = 8'h00, y_in = 8'h00, rd_data_in = 8'h00, imm_out;
  logic [15:0] pc_in = 16'h0000, rd_addr_out, addr_out;
  int fails = 0, checked = 0;

  opaddr_gen i_opaddr_gen (.clk_in, .rst_in, .start_in, .mode_in, .use_y_in, .rmw_in,
    .inh_op_in, .pc_in, .x_in, .y_in, .irq_in, .rd_req_out, .rd_addr_out, .rd_data_in,
    .done_out, .illegal_out, .imm_valid_out, .imm_out, .addr_valid_out, .addr_out, .len_out,
    .irq_level_out, .osc_stop_out, .sleep_out, .busy_out);

  always #20 clk_in = ~clk_in;

  // ==========================================================================
  // Memory: answers within the cycle a read stands; idle cycles show inverted data.
  function automatic logic [7:0] mem_at(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  function automatic logic [15:0] word_at(input logic [15:0] a);
    return {mem_at(a), mem_at({8'h00, a[7:0] + 8'h01})};
  endfunction
  function automatic logic [15:0] code_word(input logic [15:0] a);
    return {mem_at(a), mem_at(a + 16'h0001)};
  endfunction

  always @(posedge clk_in) begin
    #1;
    rd_data_in = rd_req_out ? mem_at(rd_addr_out) : ~rd_data_in;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic op(input logic [3:0] m, input logic uy, input logic rm, input logic [1:0] io,
                    input logic [15:0] pc, input logic [7:0] xv, input logic [7:0] yv);
    @(posedge clk_in);
    #1;
    {mode_in, use_y_in, rmw_in, inh_op_in, pc_in, x_in, y_in} = {m, uy, rm, io, pc, xv, yv};
    start_in = 1'b1;
    @(posedge clk_in);
    #1;
    start_in = 1'b0;
  endtask

  task automatic wait_done;
    int n = 0;
    while (done_out !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check(16'(done_out), 16'h0001, "completion");
  endtask

  // Runs one request and checks the address and the length it reports.
  task automatic addr_case(input logic [3:0] m, input logic uy, input logic [15:0] pc,
                           input logic [7:0] xv, input logic [15:0] exp, input logic [1:0] ln);
    op(m, uy, 1'b0, opaddr_pkg::OP_NONE, pc, xv, xv);
    wait_done;
    check(16'(addr_valid_out), 16'h0001, "address valid");
    check(addr_out, exp, "operand address");
    check(16'(len_out), 16'(ln), "length");
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_inherent;
    op(opaddr_pkg::MODE_INHERENT, 1'b0, 1'b0, opaddr_pkg::OP_IRQ_MASK_CLEAR, 16'h0100, 8'h00,
       8'h00);
    wait_done;
    check(16'(len_out), 16'h0000, "inherent length");
    check(16'(irq_level_out), 16'h0000, "mask cleared");
    op(opaddr_pkg::MODE_INHERENT, 1'b0, 1'b0, opaddr_pkg::OP_IRQ_MASK_SET, 16'h0101, 8'h00,
       8'h00);
    wait_done;
    check(16'(irq_level_out), 16'h0003, "mask set");
    $display("inherent test done");
  endtask

  task automatic t_immediate;
    op(opaddr_pkg::MODE_IMMEDIATE, 1'b0, 1'b0, opaddr_pkg::OP_NONE, 16'h0300, 8'h00, 8'h00);
    check(16'(busy_out), 16'h0001, "busy while fetching");
    wait_done;
    check(16'(imm_valid_out), 16'h0001, "immediate valid");
    check(16'(imm_out), 16'(mem_at(16'h0301)), "immediate value");
    check(16'(len_out), 16'h0001, "immediate length");
    check(16'(busy_out), 16'h0000, "idle when done");
    $display("immediate test done");
  endtask

  task automatic t_direct_indexed;
    addr_case(opaddr_pkg::MODE_DIR_SHORT, 1'b0, 16'h1234, 8'h00, {8'h00, mem_at(16'h1235)},
              2'h1);
    addr_case(opaddr_pkg::MODE_DIR_LONG, 1'b0, 16'h4000, 8'h00, code_word(16'h4001),
              2'h2);
    addr_case(opaddr_pkg::MODE_IDX_NONE, 1'b0, 16'h0200, 8'hC3, 16'h00C3, 2'h0);
    addr_case(opaddr_pkg::MODE_IDX_SHORT, 1'b1, 16'h0059, 8'hFF, 16'h01FE, 2'h1);
    addr_case(opaddr_pkg::MODE_IDX_LONG, 1'b0, 16'h0059, 8'h05,
              code_word(16'h005A) + 16'h0005, 2'h2);
    $display("direct and indexed test done");
  endtask

  task automatic t_indirect;
    logic [15:0] p;
    logic [15:0] q;
    p = {8'h00, mem_at(16'h0801)};
    q = {8'h00, mem_at(16'h005A)};
    addr_case(opaddr_pkg::MODE_IND_SHORT, 1'b0, 16'h0800, 8'h00, {8'h00, mem_at(p)},
              2'h1);
    addr_case(opaddr_pkg::MODE_IND_LONG, 1'b0, 16'h0059, 8'h00, word_at(q), 2'h1);
    addr_case(opaddr_pkg::MODE_INDX_SHORT, 1'b1, 16'h0800, 8'h9C,
              {8'h00, mem_at(p)} + 16'h009C, 2'h1);
    addr_case(opaddr_pkg::MODE_INDX_LONG, 1'b0, 16'h0059, 8'h7E,
              word_at(q) + 16'h007E, 2'h1);
    $display("indirect test done");
  endtask

  task automatic t_rmw_sleep;
    op(opaddr_pkg::MODE_DIR_LONG, 1'b0, 1'b1, opaddr_pkg::OP_NONE, 16'h0400, 8'h00, 8'h00);
    wait_done;
    check(16'(illegal_out), 16'h0001, "long rmw refused");
    op(opaddr_pkg::MODE_DIR_SHORT, 1'b0, 1'b1, opaddr_pkg::OP_NONE, 16'h0400, 8'h00, 8'h00);
    wait_done;
    check(16'(illegal_out), 16'h0000, "short rmw accepted");
    for (int k = 0; k < 2; k++) begin
      op(opaddr_pkg::MODE_INHERENT, 1'b0, k[0], opaddr_pkg::OP_SLEEP, 16'h0500, 8'h00, 8'h00);
      repeat (4) @(posedge clk_in);
      #1;
      check(16'(osc_stop_out), 16'(!k[0]), "oscillator stop");
      check(16'(sleep_out), 16'h0001, "sleep level");
      check(16'(done_out), 16'h0000, "still asleep");
      irq_in = 1'b1;
      wait_done;
      irq_in = 1'b0;
      check(16'(sleep_out), 16'h0000, "awake again");
      check(16'(osc_stop_out), 16'h0000, "oscillator running");
    end
    $display("rmw and sleep test done");
  endtask

  // ==========================================================================
  // Verdict, run and watchdog
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_in);
    #1 rst_in = 1'b0;
    check(16'(irq_level_out), 16'h0003, "reset mask level");
    t_inherent;
    t_immediate;
    t_direct_indexed;
    t_indirect;
    t_rmw_sleep;
    end_of_test;
  end

  // Whole run needs about 80 cycles; this allows 3000 cycles.
  initial begin
    #(40 * 3000);
    fails++;
    end_of_test;
  end

endmodule // tb_top
